// ---- common/asbl_pkg.sv ----
// Purpose: Constants for the host-side controller of an asynchronous byte-lane static memory
// Assumes: 200 MHz system clock, 16-bit memory data bus, 20-bit word address
// Notes:   Pin timing figures are kept in ns; cycle counts are derived from them
//
// Summary of operation
// R01: The memory writes only while write strobe, both selects and a byte select are all active.
// R02: A write begins once every control is active and ends when the first of them goes inactive.
// R03: Write data setup and hold are measured from the edge that ends the write.
// R04: With output enable high the memory keeps its data pins undriven.
// R05: Deselecting both selects at once with write strobe high leaves the outputs undriven.
// R06: The controller never drives the data pins while the memory may still be driving them.
// R07: The controller holds the write strobe high through every read cycle.
// R08: The address is valid no later than the select and byte-select activation edges.
// R09: With the memory selected and outputs enabled, new data follows every address change.
// R10: On a read the memory drives only the byte lanes whose selects are active.
// R11: On a write the memory stores only the byte lanes whose selects are active.
// R12: The controller always drives both chip selects to a valid logic level.
// R13: A high low-active select, a low high-active select or both byte selects high mean standby.
// R14: Selected with strobe and output enable high, the memory drives nothing and does no access.
package asbl_pkg;

  localparam int ADDR_W       = 20;
  localparam int DATA_W       = 16;
  localparam int CLK_PERIOD_PS = 5000;

  // Pin timing of the memory, in ns, and the synchroniser depth
  localparam int T_RC_NS   = 45;  // Read cycle and address to data valid
  localparam int T_PWE_NS  = 35;  // Write strobe pulse width
  localparam int T_HZOE_NS = 18;  // Output enable high to pins released
  localparam int SYNC_LAT  = 3;   // Data pin synchroniser depth

  // Least times round up
  localparam int RD_CYC = (T_RC_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS + SYNC_LAT;
  localparam int WE_CYC = (T_PWE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int HZ_CYC = (T_HZOE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

  localparam int CNT_W = 4;

  // Reset values of the pins
  localparam logic RST_SEL_N = 1'b1;
  localparam logic RST_SEL   = 1'b0;
  localparam logic RST_WE_N  = 1'b1;
  localparam logic RST_OE_N  = 1'b1;
  localparam logic RST_BS_N  = 1'b1;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_RD_ACT,
    ST_RD_REL,
    ST_WR_SET,
    ST_WR_PULSE,
    ST_WR_HOLD
  } asbl_state_type;

endpackage : asbl_pkg

// ---- common/asbl_sync_if.sv ----
// Purpose: Carries the raw data pins into the synchroniser and the settled value back
// Assumes: One clock domain on the user side
// Notes:   Raw side is written by the controller, settled side by the synchroniser
interface asbl_sync_if #(parameter int W = 16);
  logic [W-1:0] raw;
  logic [W-1:0] filt;

  modport sync_mp (input raw, output filt);
  modport user_mp (output raw, input filt);
endinterface : asbl_sync_if

// ---- hw/asbl_ctrl.sv ----
// Purpose: Host-side controller that runs single read and write cycles on a byte-lane SRAM
// Assumes: Memory pins are asynchronous; data pins come back through a synchroniser
// Notes:   One access at a time; o_ready marks when a new request can be taken
module asbl_ctrl #(
  parameter int ADDR_W = asbl_pkg::ADDR_W,
  parameter int DATA_W = asbl_pkg::DATA_W
) (
  input  wire logic              i_clk,                  // System clock, 200 MHz
  input  wire logic              i_resetn,               // Synchronous reset, active low
  input  wire logic              i_ce,                   // Clock enable, freezes all state
  input  wire logic              i_req,                  // Access request
  input  wire logic              i_wr,                   // 1 write, 0 read
  input  wire logic [ADDR_W-1:0] i_addr,                 // Word address
  input  wire logic [DATA_W-1:0] i_wdata,                // Write data
  input  wire logic [1:0]        i_be,                   // Byte enables, bit1 upper, high active
  output logic                   o_ready,                // Idle, request may be taken
  output logic                   o_rvalid,               // Read data valid pulse
  output logic [DATA_W-1:0]      o_rdata,                // Read data
  output logic [ADDR_W-1:0]      o_addr,                 // Memory address pins
  output logic                   o_select_active_low,    // Low-active chip select
  output logic                   o_select_active_high,   // High-active chip select
  output logic                   o_we_n,                 // Write strobe, active low
  output logic                   o_oe_n,                 // Output enable, active low
  output logic                   o_upper_byte_select_n,  // Upper lane select, active low
  output logic                   o_lower_byte_select_n,  // Lower lane select, active low
  output logic [DATA_W-1:0]      o_dq,                   // Data pins, driven value
  output logic                   o_dq_oe,                // Data pins, high while driven
  input  wire logic [DATA_W-1:0] i_dq                    // Data pins, sensed value
);

  localparam logic [asbl_pkg::CNT_W-1:0] RD_LAST = asbl_pkg::CNT_W'(asbl_pkg::RD_CYC - 1);
  localparam logic [asbl_pkg::CNT_W-1:0] WE_LAST = asbl_pkg::CNT_W'(asbl_pkg::WE_CYC - 1);
  localparam logic [asbl_pkg::CNT_W-1:0] HZ_LAST = asbl_pkg::CNT_W'(asbl_pkg::HZ_CYC - 1);

  ////////////////////////////////////////////////////////////////////////////////
  // Data pin synchroniser

  asbl_sync_if #(.W(DATA_W)) dq_sif ();

  assign dq_sif.raw = i_dq;

  asbl_sync #(.W(DATA_W)) u_sync (
    .i_clk    (i_clk),
    .i_resetn (i_resetn),
    .i_ce     (i_ce),
    .sif      (dq_sif)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Sequencer

  asbl_pkg::asbl_state_type  state_ff, nxt_state;
  logic [asbl_pkg::CNT_W-1:0] cnt_ff, nxt_cnt;
  logic                      ready_ff, nxt_ready;
  logic                      rvalid_ff, nxt_rvalid;
  logic [DATA_W-1:0]         rdata_ff, nxt_rdata;
  logic [ADDR_W-1:0]         addr_ff, nxt_addr;
  logic                      sel_n_ff, nxt_sel_n;
  logic                      sel_ff, nxt_sel;
  logic                      we_n_ff, nxt_we_n;
  logic                      oe_n_ff, nxt_oe_n;
  logic                      ubs_n_ff, nxt_ubs_n;
  logic                      lbs_n_ff, nxt_lbs_n;
  logic [DATA_W-1:0]         dq_ff, nxt_dq;
  logic                      dq_oe_ff, nxt_dq_oe;
  logic                      take;

  // A request with no lane enabled would be a standby cycle, so it is not taken
  assign take = i_req && ready_ff && (i_be != 2'h0);

  always_comb begin
    nxt_state  = state_ff;
    nxt_cnt    = cnt_ff;
    nxt_rvalid = 1'b0;
    nxt_rdata  = rdata_ff;
    nxt_addr   = addr_ff;
    nxt_sel_n  = sel_n_ff;
    nxt_sel    = sel_ff;
    nxt_we_n   = we_n_ff;
    nxt_oe_n   = oe_n_ff;
    nxt_ubs_n  = ubs_n_ff;
    nxt_lbs_n  = lbs_n_ff;
    nxt_dq     = dq_ff;
    nxt_dq_oe  = dq_oe_ff;
    case (state_ff)
      asbl_pkg::ST_IDLE: begin
        if (take) begin
          // Address, selects and lanes change on the same edge
          nxt_addr  = i_addr;                                          // R08
          nxt_sel_n = 1'b0;
          nxt_sel   = 1'b1;
          nxt_ubs_n = ~i_be[1];
          nxt_lbs_n = ~i_be[0];
          nxt_we_n  = 1'b1;                                            // R07
          if (i_wr) begin
            // Output enable stays high so the memory cannot drive back
            nxt_oe_n  = 1'b1;                                          // R06
            nxt_dq    = i_wdata;
            nxt_dq_oe = 1'b1;
            nxt_state = asbl_pkg::ST_WR_SET;
          end else begin
            nxt_oe_n  = 1'b0;
            nxt_cnt   = RD_LAST;
            nxt_state = asbl_pkg::ST_RD_ACT;
          end
        end
      end
      asbl_pkg::ST_RD_ACT: begin
        if (cnt_ff == '0) begin
          nxt_rdata  = dq_sif.filt;
          nxt_rvalid = 1'b1;
          nxt_oe_n   = 1'b1;
          nxt_sel_n  = 1'b1;                                           // R12
          nxt_sel    = 1'b0;
          nxt_ubs_n  = 1'b1;
          nxt_lbs_n  = 1'b1;
          nxt_cnt    = HZ_LAST;
          nxt_state  = asbl_pkg::ST_RD_REL;
        end else begin
          nxt_cnt = cnt_ff - 1'b1;
        end
      end
      asbl_pkg::ST_RD_REL: begin
        // Memory may still drive the pins until the release time is over
        if (cnt_ff == '0) begin                                        // R06
          nxt_state = asbl_pkg::ST_IDLE;
        end else begin
          nxt_cnt = cnt_ff - 1'b1;
        end
      end
      asbl_pkg::ST_WR_SET: begin
        // All other controls are active; the strobe falls last and starts the write
        nxt_we_n  = 1'b0;                                              // R02
        nxt_cnt   = WE_LAST;
        nxt_state = asbl_pkg::ST_WR_PULSE;
      end
      asbl_pkg::ST_WR_PULSE: begin
        if (cnt_ff == '0) begin
          // Strobe ends the write; data and selects stay one more cycle
          nxt_we_n  = 1'b1;                                            // R03
          nxt_state = asbl_pkg::ST_WR_HOLD;
        end else begin
          nxt_cnt = cnt_ff - 1'b1;
        end
      end
      asbl_pkg::ST_WR_HOLD: begin
        nxt_dq_oe = 1'b0;                                              // R03
        nxt_sel_n = 1'b1;                                              // R12
        nxt_sel   = 1'b0;
        nxt_ubs_n = 1'b1;
        nxt_lbs_n = 1'b1;
        nxt_state = asbl_pkg::ST_IDLE;
      end
      default: begin
        nxt_state = asbl_pkg::ST_IDLE;
      end
    endcase
    nxt_ready = (nxt_state == asbl_pkg::ST_IDLE);
  end

  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      state_ff  <= asbl_pkg::ST_IDLE;
      cnt_ff    <= '0;
      ready_ff  <= 1'b1;
      rvalid_ff <= 1'b0;
      rdata_ff  <= '0;
      addr_ff   <= '0;
      sel_n_ff  <= asbl_pkg::RST_SEL_N;                                // R12
      sel_ff    <= asbl_pkg::RST_SEL;
      we_n_ff   <= asbl_pkg::RST_WE_N;
      oe_n_ff   <= asbl_pkg::RST_OE_N;
      ubs_n_ff  <= asbl_pkg::RST_BS_N;
      lbs_n_ff  <= asbl_pkg::RST_BS_N;
      dq_ff     <= '0;
      dq_oe_ff  <= 1'b0;
    end else if (i_ce) begin
      state_ff  <= nxt_state;
      cnt_ff    <= nxt_cnt;
      ready_ff  <= nxt_ready;
      rvalid_ff <= nxt_rvalid;
      rdata_ff  <= nxt_rdata;
      addr_ff   <= nxt_addr;
      sel_n_ff  <= nxt_sel_n;
      sel_ff    <= nxt_sel;
      we_n_ff   <= nxt_we_n;
      oe_n_ff   <= nxt_oe_n;
      ubs_n_ff  <= nxt_ubs_n;
      lbs_n_ff  <= nxt_lbs_n;
      dq_ff     <= nxt_dq;
      dq_oe_ff  <= nxt_dq_oe;
    end
  end

  assign o_ready               = ready_ff;
  assign o_rvalid              = rvalid_ff;
  assign o_rdata               = rdata_ff;
  assign o_addr                = addr_ff;
  assign o_select_active_low   = sel_n_ff;
  assign o_select_active_high  = sel_ff;
  assign o_we_n                = we_n_ff;
  assign o_oe_n                = oe_n_ff;
  assign o_upper_byte_select_n = ubs_n_ff;
  assign o_lower_byte_select_n = lbs_n_ff;
  assign o_dq                  = dq_ff;
  assign o_dq_oe               = dq_oe_ff;

  ////////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_resetn || !i_ce);

  logic wr_active;
  assign wr_active = !sel_n_ff && sel_ff && (!ubs_n_ff || !lbs_n_ff);

  a_we_high_read: // R07
    assert property (!oe_n_ff |-> we_n_ff)
      else $error("Write strobe low during a read");

  a_no_drive_oe: // R06
    assert property (dq_oe_ff |-> oe_n_ff)
      else $error("Data pins driven while output enable is active");

  a_release_wait: // R06
    assert property ($rose(oe_n_ff) |-> !dq_oe_ff [*4])
      else $error("Data pins driven before the memory released them");

  a_selects_paired: // R12
    assert property (sel_n_ff == !sel_ff)
      else $error("Chip selects out of step");

  a_write_start: // R02
    assert property ($fell(we_n_ff) |-> wr_active && dq_oe_ff && $past(wr_active))
      else $error("Write strobe fell before the other controls were active");

  a_strobe_width: // R02
    assert property ($fell(we_n_ff) |-> !we_n_ff [*7] ##1 we_n_ff)
      else $error("Write strobe pulse width wrong");

  a_data_at_end: // R03
    assert property ($rose(we_n_ff) |-> dq_oe_ff && wr_active && $stable(dq_ff))
      else $error("Write data or selects gone at the ending edge");

  a_addr_steady: // R08
    assert property (!sel_n_ff && $past(!sel_n_ff) |-> $stable(addr_ff))
      else $error("Address moved while selected");

  a_read_answer: // R09
    assert property (take && !i_wr |-> ##13 rvalid_ff)
      else $error("Read data not returned on time");

  c_read:       cover property (take && !i_wr ##[1:20] rvalid_ff);
  c_write:      cover property (take && i_wr ##[1:12] $rose(we_n_ff));
  c_upper_only: cover property (take && i_wr && i_be == 2'h2);
  c_rd_then_wr: cover property (rvalid_ff ##[1:8] (take && i_wr));

endmodule : asbl_ctrl

// ---- hw/asbl_sync.sv ----
// Purpose: Three-stage synchroniser with an agreement filter for the data pins
// Assumes: Input changes asynchronously to i_clk
// Notes:   The first stage feeds only the second; output moves when stages two and three agree
module asbl_sync #(
  parameter int W = 16
) (
  input  wire logic i_clk,     // System clock
  input  wire logic i_resetn,  // Synchronous reset, active low
  input  wire logic i_ce,      // Clock enable
  asbl_sync_if.sync_mp sif     // Raw in, settled out
);

  logic [W-1:0] s1_ff;
  logic [W-1:0] s2_ff;
  logic [W-1:0] s3_ff;
  logic [W-1:0] filt_ff;
  logic [W-1:0] nxt_filt;

  always_comb begin
    // Per bit, so a released lane that keeps moving cannot hold back the driven lanes
    nxt_filt = (s3_ff & ~(s2_ff ^ s3_ff)) | (filt_ff & (s2_ff ^ s3_ff));
  end

  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      s1_ff   <= '0;
      s2_ff   <= '0;
      s3_ff   <= '0;
      filt_ff <= '0;
    end else if (i_ce) begin
      s1_ff   <= sif.raw;
      s2_ff   <= s1_ff;
      s3_ff   <= s2_ff;
      filt_ff <= nxt_filt;
    end
  end

  // Settled value leaves before its register to save one cycle of read latency
  assign sif.filt = nxt_filt;

endmodule : asbl_sync

// ---- testbench/asbl_sram_model.sv ----
// Purpose: Behavioural byte-lane static memory on the controller pins
// Assumes: Only the low AW address bits are decoded
// Notes:   Read data lags the address by RD_DLY_NS; host faults are counted
module asbl_sram_model #(
  parameter int RD_DLY_NS = 40,
  parameter int AW        = 8
) (
  input  wire logic [19:0] i_addr,    // Address
  input  wire logic        i_sel_n,   // Low-active select
  input  wire logic        i_sel,     // High-active select
  input  wire logic        i_we_n,    // Write strobe
  input  wire logic        i_oe_n,    // Output enable
  input  wire logic        i_ub_n,    // Upper lane select
  input  wire logic        i_lb_n,    // Lower lane select
  input  wire logic [15:0] i_dq,      // Resolved wire
  input  wire logic        i_host_oe, // Host drives wire
  output logic      [15:0] o_dq,      // Read value
  output logic      [1:0]  o_lane_oe, // Lane drive
  output int               o_faults   // Host faults
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0]   mem [2**AW];
  logic [15:0]   wd_q;
  logic [AW-1:0] wa_q;
  logic [1:0]    wl_q;
  logic          sel_ok;
  logic          wr_act;
  //////////////////////////////////////////////////////////////////////////////
  assign sel_ok = i_sel_n === 1'h0 && i_sel === 1'h1;
  assign wr_act = sel_ok && i_we_n === 1'h0 && !(i_ub_n && i_lb_n);
  // Old data stands until the access time runs out
  assign #(RD_DLY_NS) o_dq = mem[i_addr[AW-1:0]];
  assign o_lane_oe = (sel_ok && i_we_n === 1'h1 && i_oe_n === 1'h0) ?
                     ~{i_ub_n, i_lb_n} : 2'h0;
  always @* begin
    if (wr_act) begin
      wa_q = i_addr[AW-1:0];
      wl_q = ~{i_ub_n, i_lb_n};
      wd_q = i_dq;
    end
  end
  // Commit on whichever control ends the overlap, using values held just before
  always @(negedge wr_act) begin
    if (wl_q[0]) mem[wa_q][7:0] = wd_q[7:0];
    if (wl_q[1]) mem[wa_q][15:8] = wd_q[15:8];
  end
  //////////////////////////////////////////////////////////////////////////////
  int faults = 0;
  // One process owns the count so the port has a single driver
  always @(i_host_oe, o_lane_oe, i_sel_n, i_sel, i_we_n, i_oe_n) begin
    if (i_host_oe === 1'h1 && o_lane_oe != 2'h0) faults++;
    if ($isunknown({i_sel_n, i_sel})) faults++;
    if (sel_ok && i_we_n === 1'h0 && i_oe_n === 1'h0) faults++;
  end
  assign o_faults = faults;
endmodule : asbl_sram_model

// ---- testbench/asbl_tb_top.sv ----
// Purpose: Self-checking bench for the byte-lane static memory controller
// Assumes: 200 MHz clock; memory model decodes 8 address bits
// Notes:   Released lanes show a pattern that flips every cycle
module asbl_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        i_clk, i_resetn = 1'h0, i_ce = 1'h1, i_req = 1'h0, i_wr = 1'h0;
  logic        o_ready, o_rvalid, o_we_n, o_oe_n, o_dq_oe, sel_q = 1'h0;
  logic        o_select_active_low, o_select_active_high;
  logic        o_upper_byte_select_n, o_lower_byte_select_n;
  logic [19:0] i_addr = 20'h0, o_addr, addr_q;
  logic [15:0] i_wdata = 16'h0, o_rdata, o_dq, dq_w, m_dq, flt = 16'h5a5a;
  logic [15:0] exp_mem [256];
  logic [1:0]  i_be = 2'h0, lane_oe;
  int          n_fail = 0, n_checks = 0, we_run = 0, m_faults, base;
  //////////////////////////////////////////////////////////////////////////////
  asbl_ctrl uut (
    .i_clk, .i_resetn, .i_ce, .i_req, .i_wr, .i_addr, .i_wdata, .i_be, .o_ready, .o_rvalid,
    .o_rdata, .o_addr, .o_select_active_low, .o_select_active_high, .o_we_n, .o_oe_n,
    .o_upper_byte_select_n, .o_lower_byte_select_n, .o_dq, .o_dq_oe, .i_dq(dq_w)
  );
  asbl_sram_model #(.RD_DLY_NS(40), .AW(8)) mdl (
    .i_addr(o_addr), .i_sel_n(o_select_active_low), .i_sel(o_select_active_high),
    .i_we_n(o_we_n), .i_oe_n(o_oe_n), .i_ub_n(o_upper_byte_select_n),
    .i_lb_n(o_lower_byte_select_n), .i_dq(dq_w), .i_host_oe(o_dq_oe), .o_dq(m_dq),
    .o_lane_oe(lane_oe), .o_faults(m_faults)
  );
  assign dq_w[7:0]  = o_dq_oe ? o_dq[7:0]  : (lane_oe[0] ? m_dq[7:0]  : flt[7:0]);
  assign dq_w[15:8] = o_dq_oe ? o_dq[15:8] : (lane_oe[1] ? m_dq[15:8] : flt[15:8]);
  initial begin
    i_clk = 1'h0;
    forever #2.5 i_clk = ~i_clk;
  end
  //////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic stop_test();
    if (n_fail == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : stop_test
  // Pin watcher: sees register values from before each edge
  always @(posedge i_clk) begin
    flt <= ~flt;
    if (i_resetn) begin
      chk("sel_pair", o_select_active_high, !o_select_active_low);
      if (o_oe_n === 1'h0) chk("we_in_read", o_we_n, 1'h1);
      if (o_dq_oe === 1'h1) chk("oe_off", o_oe_n, 1'h1);
      if (sel_q && o_select_active_low === 1'h0) chk("addr_hold", o_addr, addr_q);
      if (o_we_n === 1'h0) begin
        we_run++;
        chk("wr_qual", {o_select_active_low, o_select_active_high, o_dq_oe,
            o_upper_byte_select_n & o_lower_byte_select_n}, 4'h6);
      end else if (we_run != 0) begin
        chk("we_width", we_run, asbl_pkg::WE_CYC);
        chk("data_hold", {o_dq_oe, o_select_active_low}, 2'h2);
        we_run = 0;
      end
      sel_q  = o_select_active_low === 1'h0;
      addr_q = o_addr;
    end
  end
  // One access; st cycles of clock-enable stall are inserted after cycle 4
  task automatic access(input logic w, input logic [19:0] a, input logic [15:0] d,
                        input logic [1:0] be, input int st, output logic [15:0] q);
    int          n;
    int          rv_at;
    logic [15:0] mask;
    n     = 0;
    rv_at = 0;
    mask  = {{8{be[1]}}, {8{be[0]}}};
    @(posedge i_clk);
    i_req   <= 1'h1;
    i_wr    <= w;
    i_addr  <= a;
    i_wdata <= d;
    i_be    <= be;
    @(posedge i_clk);
    i_req <= 1'h0;
    while (o_ready !== 1'h1 || n == 0) begin
      @(posedge i_clk);
      #1;
      n++;
      if (n == 1) chk("lanes", {o_select_active_low, o_upper_byte_select_n,
                      o_lower_byte_select_n}, {1'h0, ~be});
      if (n == 4 && st > 0) begin
        i_ce <= 1'h0;
        repeat (st) @(posedge i_clk);
        i_ce <= 1'h1;
      end
      if (o_rvalid === 1'h1) begin
        rv_at = (rv_at == 0) ? n : -1;
        q     = o_rdata;
      end
      if (n > 40) begin
        chk("timeout", n, 0);
        stop_test();
      end
    end
    // n counts edges after the take edge, the first one counting as 1
    chk("done_cycle", n, w ? 9 : 16);
    chk("rvalid_at", rv_at, w ? 0 : 12);
    if (w) exp_mem[a[7:0]] = (exp_mem[a[7:0]] & ~mask) | (d & mask);
    else chk("rdata", q & mask, exp_mem[a[7:0]] & mask);
  endtask : access
  //////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    chk("rst_pins", {o_ready, o_rvalid, o_select_active_low, o_select_active_high, o_we_n,
        o_oe_n, o_upper_byte_select_n, o_lower_byte_select_n, o_dq_oe}, 9'h15e);
    chk("rst_vals", |{o_addr, o_rdata, o_dq}, 1'h0);
  endtask : t_reset
  task automatic t_words();
    logic [19:0] a [3];
    logic [15:0] q;
    a = '{20'h00000, 20'hfffff, 20'h5a5a3};
    for (int i = 0; i < 3; i++) access(1'h1, a[i], 16'hc3a5 ^ {4{a[i][3:0]}}, 2'h3, 0, q);
    for (int i = 0; i < 3; i++) access(1'h0, a[i], 16'h0, 2'h3, 0, q);
  endtask : t_words
  task automatic t_lanes();
    logic [15:0] q;
    access(1'h1, 20'h00011, 16'h1234, 2'h3, 0, q);
    access(1'h1, 20'h00011, 16'habcd, 2'h2, 0, q);
    access(1'h1, 20'h00022, 16'h7e81, 2'h1, 0, q);
    access(1'h0, 20'h00011, 16'h0, 2'h3, 3, q);
    access(1'h0, 20'h00011, 16'h0, 2'h1, 0, q);
    access(1'h0, 20'h00022, 16'h0, 2'h1, 0, q);
  endtask : t_lanes
  task automatic t_refused();
    logic [15:0] q;
    @(posedge i_clk);
    i_req  <= 1'h1;
    i_wr   <= 1'h1;
    i_be   <= 2'h0;
    i_addr <= 20'h00011;
    repeat (3) @(posedge i_clk);
    #1;
    chk("no_take", {o_ready, o_select_active_low, o_we_n}, 3'h7);
    i_req <= 1'h0;
    access(1'h0, 20'h00011, 16'h0, 2'h3, 0, q);
  endtask : t_refused
  initial begin
    repeat (16) @(posedge i_clk);
    i_resetn <= 1'h1;
    @(posedge i_clk);
    #1;
    base = m_faults;
    t_reset();
    t_words();
    t_lanes();
    t_refused();
    chk("host_faults", m_faults, base);
    stop_test();
  end
endmodule : asbl_tb_top
